// ---- bench/atc_cell_src.sv ----
module atc_cell_src (
   input wire clk,
   input wire avail,
   output reg [7:0] data,
   output reg soc,
   output reg enable_n,
   output reg parity
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      data = 8'h00;
      soc = 1'b0;
      enable_n = 1'b1;
      parity = 1'b1;
   end
   // A released bus shows junk rather than its last byte
   task send(input [31:0] hdr, input bad);
      integer i;
      begin
         while (avail !== 1'b1)
            @(posedge clk);
         for (i = 0; i < 53; i = i + 1) begin
            @(posedge clk);
            #1;
            if (i == 30) begin
               enable_n = 1'b1;
               data = ~data;
               @(posedge clk);
               #1;
            end
            soc = (i == 0);
            enable_n = 1'b0;
            data = (i < 4) ? hdr[31 - 8 * i -: 8] : i[7:0];
            parity = ~^data ^ (bad && i == 9);
         end
         @(posedge clk);
         #1;
         enable_n = 1'b1;
         data = ~data;
      end
   endtask
endmodule // atc_cell_src

// ---- bench/atc_tx_cell_checker.sv ----
module atc_tx_cell_checker (
   input wire clk,
   input wire reset,
   input wire [8:0] up_addr,
   input wire [7:0] up_wdata,
   input wire up_wr,
   input wire up_rd,
   input wire [7:0] up_rdata,
   input wire tx_bus_soc,
   input wire tx_bus_enable_n,
   input wire tx_bus_cell_avail,
   input wire ins_valid,
   input wire ins_ready,
   input wire ext_valid,
   input wire ext_sof,
   input wire [7:0] out_byte,
   input wire out_sof,
   input wire out_valid,
   input wire out_ready,
   input wire out_concat
);
   logic [5:0] out_cnt_r;
   logic [5:0] ins_cnt_r;
   // Octet positions, so framing is judged without looking inside the design
   always @(posedge clk or posedge reset) begin
      if (reset)
         out_cnt_r <= 6'h00;
      else if (out_valid && out_ready)
         out_cnt_r <= (out_cnt_r == 6'h34) ? 6'h00 : out_cnt_r + 6'h01;
   end
   always @(posedge clk or posedge reset) begin
      if (reset)
         ins_cnt_r <= 6'h00;
      else if (ins_valid && ins_ready)
         ins_cnt_r <= (ins_cnt_r == 6'h34) ? 6'h00 : ins_cnt_r + 6'h01;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence wr_upper;
      up_wr && up_addr == 9'h100;
   endsequence
   dual_mode_a: assert property (wr_upper ##0 up_wdata[1:0] == 2'h1 |-> ##[1:3] out_concat)
      else $error("mapper select wrong for dual mode");
   single_mode_a: assert property (wr_upper ##0 up_wdata[1:0] == 2'h3 |-> ##[1:3] !out_concat)
      else $error("mapper select wrong for single mode");
   ro_upper_a: assert property (up_rd && up_addr == 9'h100 |=> !up_rdata[2])
      else $error("read-only bit set in upper register");
   ro_lower_a: assert property (up_rd && up_addr == 9'h103 |=> (up_rdata & 8'h1a) == 8'h00)
      else $error("read-only bits set in lower register");
   cell_frame_a: assert property (out_valid |-> out_sof == (out_cnt_r == 6'h00))
      else $error("start flag off the cell boundary");
   out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_byte))
      else $error("output byte changed while stalled");
   room_flag_a: assert property (tx_bus_soc && !tx_bus_enable_n |-> ##[1:4] !tx_bus_cell_avail)
      else $error("cell room flag stayed high during a cell");
   ins_full_a: assert property (ins_valid && ins_ready && ins_cnt_r == 6'h34 |=> !ins_ready)
      else $error("insertion buffer took a byte past a cell");
   ext_frame_a: assert property (ext_sof |-> ext_valid)
      else $error("extraction start without byte");
endmodule // atc_tx_cell_checker

// ---- bench/atm_tx_cell_processor_test.sv ----
module atm_tx_cell_processor_test;
   timeunit 1ns;
   timeprecision 1ns;
   reg clk, reset, up_wr, up_rd, out_ready, ins_valid, scramble_en, f;
   reg parity_discard_en, filter_discard_en, extract_en, hec_insert_en;
   reg [8:0] up_addr;
   reg [7:0] up_wdata, ins_byte;
   reg [31:0] filter_pattern, filter_mask;
   wire [7:0] up_rdata, ext_byte, out_byte, tx_bus_data;
   wire tx_bus_soc, tx_bus_enable_n, tx_bus_parity, tx_bus_cell_avail, ins_ready;
   wire ext_valid, ext_sof, out_sof, out_valid, out_concat;
   reg [7:0] c [0:52];
   integer error_cnt = 0, tests_run = 0, ext_n = 0, cyc = 0;
   atc_tx_cell dut (.clk, .reset, .up_addr, .up_wdata, .up_wr, .up_rd, .up_rdata, .tx_bus_data,
      .tx_bus_soc, .tx_bus_enable_n, .tx_bus_parity, .tx_bus_cell_avail, .parity_discard_en,
      .filter_discard_en, .extract_en, .hec_insert_en, .scramble_en, .filter_pattern,
      .filter_mask, .ins_byte, .ins_valid, .ins_ready, .ext_byte, .ext_valid, .ext_sof,
      .out_byte, .out_sof, .out_valid, .out_ready, .out_concat);
   atc_cell_src src (.clk, .avail(tx_bus_cell_avail), .data(tx_bus_data), .soc(tx_bus_soc),
      .enable_n(tx_bus_enable_n), .parity(tx_bus_parity));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (ext_valid === 1'b1)
         ext_n = ext_n + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         results;
      end
   end
   task results;
      begin
         if (error_cnt == 0 && tests_run > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task chk(input [8*10-1:0] nm, input [31:0] s, input [31:0] e);
      begin
         tests_run = tests_run + 1;
         if (s !== e) begin
            error_cnt = error_cnt + 1;
            $display("unexpected %0s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   function [7:0] check_byte(input [31:0] h);
      integer i;
      reg [7:0] r;
      begin
         r = 8'h00;
         for (i = 31; i >= 0; i = i - 1)
            r = {r[6:0], 1'b0} ^ ((r[7] ^ h[i]) ? 8'h07 : 8'h00);
         check_byte = r ^ 8'h55;
      end
   endfunction
   // Idle cycle after each access keeps the strobes from toggling twice in one step
   task wr(input [8:0] a, input [7:0] d);
      begin
         up_addr = a;
         up_wdata = d;
         up_wr = 1'b1;
         @(posedge clk);
         #1 up_wr = 1'b0;
         @(posedge clk);
         #1;
      end
   endtask
   task rd(input [8:0] a, input [7:0] e);
      begin
         up_addr = a;
         up_rd = 1'b1;
         @(posedge clk);
         #1 up_rd = 1'b0;
         @(posedge clk);
         #1 chk("rdata", up_rdata, e);
      end
   endtask
   // Stalls one cycle in four so the output buffer must hold its bytes
   task get_cell;
      integer n, k;
      begin
         n = 0;
         for (k = 1; n < 53 && k < 2000; k = k + 1) begin
            // Judge the handshake mid-cycle, where it is settled before the popping edge
            @(negedge clk);
            if (out_valid === 1'b1 && out_ready && (n > 0 || out_sof)) begin
               c[n] = out_byte;
               n = n + 1;
            end
            @(posedge clk);
            #1 out_ready = (k % 4) != 0;
         end
         out_ready = 1'b1;
         chk("cell_len", n, 53);
      end
   endtask
   task find(input [31:0] h);
      integer j;
      begin
         f = 1'b0;
         for (j = 0; j < 6 && !f; j = j + 1) begin
            get_cell;
            f = {c[0], c[1], c[2], c[3]} === h;
         end
      end
   endtask
   task send_find(input [31:0] h, input bad);
      fork
         src.send(h, bad);
         find(h);
      join
   endtask
   task body(input [31:0] h, input hon, input idle);
      integer i;
      begin
         chk("chk_byte", c[4], hon ? check_byte(h) : 8'h04);
         for (i = 5; i < 53; i = i + 1)
            chk("payload", c[i], idle ? 8'h6a : i);
      end
   endtask
   task t_regs;
      begin
         rd(9'h100, 8'h00);
         rd(9'h103, 8'h00);
         wr(9'h100, 8'hff);
         rd(9'h100, 8'hfb);
         chk("concat", out_concat, 1'b0);
         wr(9'h100, 8'h01);
         rd(9'h100, 8'h01);
         chk("concat", out_concat, 1'b1);
         wr(9'h100, 8'h03);
         wr(9'h103, 8'he4);
         rd(9'h103, 8'he4);
         wr(9'h103, 8'h00);
         rd(9'h101, 8'h00);
      end
   endtask
   task t_idle(input scr);
      begin
         scramble_en = scr;
         get_cell;
         find(32'h00000001);
         chk("idle", f, 1'b1);
         if (scr)
            chk("chk_byte", c[4], check_byte(32'h00000001));
         else
            body(32'h00000001, 1'b1, 1'b1);
      end
   endtask
   task t_user;
      integer k;
      begin
         for (k = 0; k < 2; k = k + 1) begin
            hec_insert_en = k[0];
            send_find(32'h0a0b0c0d, 1'b0);
            chk("user", f, 1'b1);
            body(32'h0a0b0c0d, k[0], 1'b0);
         end
         chk("extract", ext_n, 106);
      end
   endtask
   task t_drop;
      begin
         filter_discard_en = 1'b1;
         send_find(32'h11111111, 1'b0);
         chk("filtered", f, 1'b0);
         send_find(32'h0a0b0c0d, 1'b1);
         chk("bad_parity", f, 1'b0);
         chk("extract", ext_n, 106);
         filter_discard_en = 1'b0;
      end
   endtask
   task t_insert;
      integer n, tk;
      begin
         fork
            begin
               n = 0;
               while (n < 53) begin
                  ins_valid = 1'b1;
                  ins_byte = (n < 4) ? 8'h05 + n[7:0] : n[7:0];
                  // Ready is sampled before the edge that takes the byte
                  @(negedge clk);
                  tk = (ins_ready === 1'b1);
                  @(posedge clk);
                  #1;
                  n = n + tk;
               end
               ins_valid = 1'b0;
            end
            find(32'h05060708);
         join
         ins_valid = 1'b0;
         chk("inserted", f, 1'b1);
         body(32'h05060708, 1'b1, 1'b0);
      end
   endtask
   task t_proto;
      begin
         wr(9'h103, 8'h04);
         repeat (150) @(posedge clk);
         #1 chk("stopped", out_valid, 1'b0);
         wr(9'h103, 8'h00);
         get_cell;
         chk("resumed", c[3], 8'h01);
      end
   endtask
   initial begin
      {reset, up_wr, up_rd, out_ready, ins_valid} = 5'h12;
      {up_addr, up_wdata, ins_byte} = 25'h0000000;
      {parity_discard_en, filter_discard_en, extract_en, hec_insert_en, scramble_en} = 5'h17;
      filter_pattern = 32'h0a0b0c0d;
      filter_mask = 32'hffffffff;
      repeat (20) @(posedge clk);
      #1 reset = 1'b0;
      t_regs;
      t_idle(1'b1);
      t_idle(1'b0);
      t_user;
      t_drop;
      t_insert;
      t_proto;
      results;
   end
endmodule // atm_tx_cell_processor_test
bind atc_tx_cell atc_tx_cell_checker chk_i (.clk, .reset, .up_addr, .up_wdata, .up_wr, .up_rd,
   .up_rdata, .tx_bus_soc, .tx_bus_enable_n, .tx_bus_cell_avail, .ins_valid, .ins_ready,
   .ext_valid, .ext_sof, .out_byte, .out_sof, .out_valid, .out_ready, .out_concat);

// ---- hw/atc_consts.vh ----
`ifndef ATC_CONSTS_VH
`define ATC_CONSTS_VH
// Register map, microprocessor port
`define ATC_ADDR_OP_UPPER 9'h100
`define ATC_ADDR_OP_LOWER 9'h103
`define ATC_OP_UPPER_RST 8'h00
`define ATC_OP_LOWER_RST 8'h00
`define ATC_OP_UPPER_WMASK 8'hfb
`define ATC_OP_LOWER_WMASK 8'he5
// Field positions
`define ATC_CONF_LSB 0
`define ATC_PROTO_BIT 2
`define ATC_SRST_BIT 0
// Config select codes
`define ATC_CONF_STS3C_DS3 2'h1
`define ATC_CONF_STS3 2'h3
// Cell geometry
`define ATC_CELL_BYTES 6'h35
`define ATC_HDR_BYTES 6'h04
`define ATC_HEC_POS 6'h04
`define ATC_CELL_SLOTS 3'h4
// Header check byte
`define ATC_HEC_COSET 8'h55
`define ATC_HEC_POLY 8'h07
// Idle cell content
`define ATC_IDLE_HDR 32'h00000001
`define ATC_IDLE_PAYLOAD 8'h6a
`endif

// ---- hw/atc_tx_cell.v ----
`include "atc_consts.vh"

// Operation
// - Config 11 selects single STS-3 operation
// - Config 01 selects STS-3c plus DS3/E3
// - Protocol bit: 0 cells, 1 packets; here a 1 only stops cell output, no packets are sent
// - Accepted bus cells stored in transmit FIFO
// - Cell-available flag prevents FIFO overrun
// - Check parity, optionally drop bad cells
// - Header filter optionally drops failing cells
// - Matching cells copied to extraction buffer
// - Header check byte inserted at octet five
// - Scramble payload octets 6 to 53 only
// - Insertion buffer drained when FIFO empty
// - Idle cells generated when both empty
// - Idle cells fill every unused slot
// - Inserted cells get same HEADER_CHECK_BYTE, scrambling
// - Forward cells to STS-3c or STS-1 mapper
// - Mapper places cells into payload envelope
// - Transport overhead added to every frame
module atc_tx_cell (
   input wire clk,
   input wire reset,
   input wire [8:0] up_addr,
   input wire [7:0] up_wdata,
   input wire up_wr,
   input wire up_rd,
   output reg [7:0] up_rdata,
   input wire [7:0] tx_bus_data,
   input wire tx_bus_soc,
   input wire tx_bus_enable_n,
   input wire tx_bus_parity,
   output reg tx_bus_cell_avail,
   input wire parity_discard_en,
   input wire filter_discard_en,
   input wire extract_en,
   input wire hec_insert_en,
   input wire scramble_en,
   input wire [31:0] filter_pattern,
   input wire [31:0] filter_mask,
   input wire [7:0] ins_byte,
   input wire ins_valid,
   output reg ins_ready,
   output reg [7:0] ext_byte,
   output reg ext_valid,
   output reg ext_sof,
   output reg [7:0] out_byte,
   output reg out_sof,
   output reg out_valid,
   input wire out_ready,
   output reg out_concat
);
   localparam S_PICK = 1'b0;
   localparam S_SEND = 1'b1;
   localparam SRC_FIFO = 2'h0;
   localparam SRC_INS = 2'h1;
   localparam SRC_IDLE = 2'h2;

   reg [7:0] op_upper_r;
   reg [7:0] op_lower_r;
   reg [10:0] sync1_r;
   reg [10:0] sync2_r;
   reg [7:0] fifo_mem [0:255];
   reg [7:0] ins_mem [0:63];
   reg [1:0] wr_cell_r;
   reg [5:0] wr_idx_r;
   reg in_cell_r;
   reg wr_perr_r;
   reg [1:0] rd_cell_r;
   reg [2:0] cnt_r;
   reg [5:0] ins_idx_r;
   reg ins_full_r;
   reg state_r;
   reg [1:0] src_r;
   reg [5:0] idx_r;
   reg copy_r;
   reg [31:0] hdr_r;
   reg [42:0] scr_r;
   reg [8:0] buf0_r;
   reg [8:0] buf1_r;
   reg [1:0] bcnt_r;

   wire sreset = op_lower_r[`ATC_SRST_BIT];
   wire cell_mode = ~op_lower_r[`ATC_PROTO_BIT];
   wire [1:0] conf = op_upper_r[`ATC_CONF_LSB +: 2];
   wire [7:0] s_data = sync2_r[7:0];
   wire s_soc = sync2_r[8];
   wire s_en = ~sync2_r[9];
   wire s_par = sync2_r[10];
   wire buf_ready = (bcnt_r != 2'h2);

   // Register port: bit 2 of the upper byte and bits 1, 3 and 4 of the lower byte stay zero
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         op_upper_r <= `ATC_OP_UPPER_RST;
         op_lower_r <= `ATC_OP_LOWER_RST;
         up_rdata <= 8'h00;
         out_concat <= 1'b0;
      end else begin
         if (up_wr && up_addr == `ATC_ADDR_OP_UPPER)
            op_upper_r <= up_wdata & `ATC_OP_UPPER_WMASK;
         if (up_wr && up_addr == `ATC_ADDR_OP_LOWER)
            op_lower_r <= up_wdata & `ATC_OP_LOWER_WMASK;
         if (up_rd) begin
            case (up_addr)
               `ATC_ADDR_OP_UPPER: up_rdata <= op_upper_r;
               `ATC_ADDR_OP_LOWER: up_rdata <= op_lower_r;
               default: up_rdata <= 8'h00;
            endcase
         end
         // Concatenated mapper for config 01, per-channel mapper otherwise
         out_concat <= (conf == `ATC_CONF_STS3C_DS3);
      end
   end

   // Cell bus pins come from another clock source
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         sync1_r <= 11'h200;
         sync2_r <= 11'h200;
      end else begin
         sync1_r <= {tx_bus_parity, tx_bus_enable_n, tx_bus_soc, tx_bus_data};
         sync2_r <= sync1_r;
      end
   end

   // Header check byte: CRC-8 over four octets, then coset
   function [7:0] hec_of;
      input [31:0] h;
      integer i;
      reg [7:0] c;
      begin
         c = 8'h00;
         for (i = 31; i >= 0; i = i - 1)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? `ATC_HEC_POLY : 8'h00);
         hec_of = c ^ `ATC_HEC_COSET;
      end
   endfunction

   // Self-synchronous x^43+1 payload scrambler, MSB first
   function [50:0] scr_of;
      input [7:0] d;
      input [42:0] s;
      integer i;
      reg [42:0] st;
      reg [7:0] o;
      begin
         st = s;
         o = 8'h00;
         for (i = 7; i >= 0; i = i - 1) begin
            o[i] = d[i] ^ st[42];
            st = {st[41:0], o[i]};
         end
         scr_of = {st, o};
      end
   endfunction

   // Write side of the transmit FIFO
   wire start_ok = s_en && s_soc && (cnt_r != `ATC_CELL_SLOTS);
   wire byte_ok = s_en && !s_soc && in_cell_r;
   wire last_wr = byte_ok && (wr_idx_r == `ATC_CELL_BYTES - 6'h01);
   wire bad_par = ~(^{s_data, s_par});
   wire cell_perr = wr_perr_r | bad_par;
   wire commit = last_wr && !(parity_discard_en && cell_perr);

   always @(posedge clk) begin
      if (start_ok)
         fifo_mem[{wr_cell_r, 6'h00}] <= s_data;
      else if (byte_ok)
         fifo_mem[{wr_cell_r, wr_idx_r}] <= s_data;
      if (ins_valid && ins_ready)
         ins_mem[ins_idx_r] <= ins_byte;
   end

   // Read side decision
   wire [7:0] fb0 = fifo_mem[{rd_cell_r, 6'h00}];
   wire [7:0] fb1 = fifo_mem[{rd_cell_r, 6'h01}];
   wire [7:0] fb2 = fifo_mem[{rd_cell_r, 6'h02}];
   wire [7:0] fb3 = fifo_mem[{rd_cell_r, 6'h03}];
   wire [31:0] fhdr = {fb0, fb1, fb2, fb3};
   wire [31:0] ihdr = {ins_mem[0], ins_mem[1], ins_mem[2], ins_mem[3]};
   wire fmatch = (((fhdr ^ filter_pattern) & filter_mask) == 32'h0);
   wire pick = (state_r == S_PICK) && cell_mode && (bcnt_r == 2'h0);
   wire fdrop = pick && (cnt_r != 3'h0) && filter_discard_en && !fmatch;
   wire last_rd = (state_r == S_SEND) && buf_ready &&
      (idx_r == `ATC_CELL_BYTES - 6'h01);
   wire fifo_done = (last_rd && src_r == SRC_FIFO) || fdrop;

   reg [7:0] raw;
   reg [7:0] sent;
   reg [42:0] scr_nxt;
   always @* begin
      raw = `ATC_IDLE_PAYLOAD;
      if (src_r == SRC_FIFO)
         raw = fifo_mem[{rd_cell_r, idx_r}];
      else if (src_r == SRC_INS)
         raw = ins_mem[idx_r];
      else if (idx_r < `ATC_HDR_BYTES)
         raw = hdr_r[8'd31 - {idx_r[1:0], 3'h0} -: 8];
      sent = raw;
      scr_nxt = scr_r;
      if (idx_r == `ATC_HEC_POS) begin
         if (hec_insert_en)
            sent = hec_of(hdr_r);
      end else if (idx_r > `ATC_HEC_POS && scramble_en) begin
         {scr_nxt, sent} = scr_of(raw, scr_r);
      end
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_cell_r <= 2'h0;
         wr_idx_r <= 6'h00;
         in_cell_r <= 1'b0;
         wr_perr_r <= 1'b0;
         rd_cell_r <= 2'h0;
         cnt_r <= 3'h0;
         tx_bus_cell_avail <= 1'b0;
         ins_idx_r <= 6'h00;
         ins_full_r <= 1'b0;
         ins_ready <= 1'b0;
         state_r <= S_PICK;
         src_r <= SRC_IDLE;
         idx_r <= 6'h00;
         copy_r <= 1'b0;
         hdr_r <= 32'h0;
         scr_r <= 43'h0;
         ext_byte <= 8'h00;
         ext_valid <= 1'b0;
         ext_sof <= 1'b0;
      end else if (sreset) begin
         wr_idx_r <= 6'h00;
         in_cell_r <= 1'b0;
         wr_perr_r <= 1'b0;
         wr_cell_r <= 2'h0;
         rd_cell_r <= 2'h0;
         cnt_r <= 3'h0;
         tx_bus_cell_avail <= 1'b0;
         ins_idx_r <= 6'h00;
         ins_full_r <= 1'b0;
         ins_ready <= 1'b0;
         state_r <= S_PICK;
         idx_r <= 6'h00;
         copy_r <= 1'b0;
         ext_valid <= 1'b0;
         ext_sof <= 1'b0;
      end else begin
         // A new start of cell restarts the slot, so a runt is dropped
         if (start_ok) begin
            in_cell_r <= 1'b1;
            wr_idx_r <= 6'h01;
            wr_perr_r <= bad_par;
         end else if (byte_ok) begin
            wr_idx_r <= wr_idx_r + 6'h01;
            wr_perr_r <= cell_perr;
            if (last_wr)
               in_cell_r <= 1'b0;
         end
         if (commit)
            wr_cell_r <= wr_cell_r + 2'h1;
         if (fifo_done)
            rd_cell_r <= rd_cell_r + 2'h1;
         cnt_r <= cnt_r + {2'h0, commit} - {2'h0, fifo_done};
         // Room for a whole cell is announced only after the previous one is counted
         tx_bus_cell_avail <= (cnt_r + {2'h0, commit} - {2'h0, fifo_done} <
            `ATC_CELL_SLOTS) && !in_cell_r && !start_ok;

         if (ins_valid && ins_ready) begin
            ins_idx_r <= ins_idx_r + 6'h01;
            if (ins_idx_r == `ATC_CELL_BYTES - 6'h01) begin
               ins_full_r <= 1'b1;
               ins_ready <= 1'b0;
            end
         end else if (last_rd && src_r == SRC_INS) begin
            ins_full_r <= 1'b0;
            ins_idx_r <= 6'h00;
            ins_ready <= 1'b1;
         end else if (!ins_full_r) begin
            ins_ready <= 1'b1;
         end

         ext_valid <= 1'b0;
         ext_sof <= 1'b0;
         case (state_r)
            S_PICK: begin
               if (pick && !fdrop) begin
                  state_r <= S_SEND;
                  idx_r <= 6'h00;
                  copy_r <= 1'b0;
                  if (cnt_r != 3'h0) begin
                     src_r <= SRC_FIFO;
                     hdr_r <= fhdr;
                     copy_r <= extract_en && fmatch;
                  end else if (ins_full_r) begin
                     src_r <= SRC_INS;
                     hdr_r <= ihdr;
                  end else begin
                     src_r <= SRC_IDLE;
                     hdr_r <= `ATC_IDLE_HDR;
                  end
               end
            end
            S_SEND: begin
               if (buf_ready) begin
                  idx_r <= idx_r + 6'h01;
                  scr_r <= scr_nxt;
                  if (copy_r) begin
                     ext_byte <= raw;
                     ext_valid <= 1'b1;
                     ext_sof <= (idx_r == 6'h00);
                  end
                  if (last_rd)
                     state_r <= S_PICK;
               end
            end
            default: state_r <= S_PICK;
         endcase
      end
   end

   // Two-entry output buffer; a stalled mapper holds the sender in S_SEND
   wire push = (state_r == S_SEND) && buf_ready && !sreset;
   wire pop = out_ready && (bcnt_r != 2'h0);
   wire [8:0] pdata = {(idx_r == 6'h00), sent};
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         buf0_r <= 9'h000;
         buf1_r <= 9'h000;
         bcnt_r <= 2'h0;
      end else begin
         case ({push, pop})
            2'b10: begin
               if (bcnt_r == 2'h0)
                  buf0_r <= pdata;
               else
                  buf1_r <= pdata;
               bcnt_r <= bcnt_r + 2'h1;
            end
            2'b01: begin
               buf0_r <= buf1_r;
               bcnt_r <= bcnt_r - 2'h1;
            end
            2'b11: begin
               if (bcnt_r == 2'h1)
                  buf0_r <= pdata;
               else begin
                  buf0_r <= buf1_r;
                  buf1_r <= pdata;
               end
            end
            default: bcnt_r <= bcnt_r;
         endcase
      end
   end

   // Mapper hand-off: envelope and overhead building lie downstream
   always @* begin
      out_byte = buf0_r[7:0];
      out_sof = buf0_r[8];
      out_valid = (bcnt_r != 2'h0);
   end
endmodule // atc_tx_cell
